// ===== bioc_pkg.sv
// bioc_pkg: constants, register map and field layout of the binary I/O
// conditioning block.
// assumes a 10 MHz device clock and a plain single-cycle register port.
//
// Function
// - input change taken at once, timer starts
// - accepted state held until debounce timer expires
// - per-input polarity inversion of conditioned input
// - seven trigger slots per output, ORed together
// - per-slot inversion before the OR
// - unassigned slot always contributes zero
// - per-output collective inversion of combined state
// - no slot assigned: combined state forced zero
// - energize principle selects working or closed-circuit coil
// - unlatched contact follows combined state continuously
// - latched contact holds set state until acknowledged
// - own clear signal releases latch once triggers drop
// - acknowledge only after triggers drop and retention elapses
// - contact held at least minimum dwell after change
// - latch clears on panel, own, unlatch, unassigned
// - latched states restored from retained storage after restart
// - global clear all latches, only with remote permit
// - health LED flashes during boot, steady afterwards
// - health contact energized after clean boot, no fault

package bioc_pkg;

   // ------------
   // timing
   // ------------
   localparam int CLK_HZ        = 10_000_000;
   localparam int TICK_TIME_US  = 1000;
   localparam int TICK_CYC      = CLK_HZ / 1_000_000 * TICK_TIME_US;
   localparam int FLASH_TIME_MS = 250;
   localparam int FLASH_TICKS   = FLASH_TIME_MS * 1000 / TICK_TIME_US;

   // ------------
   // widths and counts
   // ------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int T_W    = 16;
   localparam int SRC_W  = 4;
   localparam int N_SLOT = 7;
   localparam int N_IN   = 8;
   localparam int N_EXT  = 7;
   localparam int N_SRC  = 1 + N_IN + N_EXT;

   // ------------
   // register map (word addresses)
   // ------------
   localparam logic [ADDR_W-1:0] A_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] A_IN_INV   = 8'h01;
   localparam logic [ADDR_W-1:0] A_CMD      = 8'h02;
   localparam logic [ADDR_W-1:0] A_DIN      = 8'h03;
   localparam logic [ADDR_W-1:0] A_OUT      = 8'h04;
   localparam logic [ADDR_W-1:0] A_LATCH    = 8'h05;
   localparam logic [ADDR_W-1:0] A_HEALTH   = 8'h06;
   localparam logic [ADDR_W-1:0] A_DB_BASE  = 8'h10;
   localparam logic [ADDR_W-1:0] A_OUT_BASE = 8'h20;
   localparam int                OUT_STRIDE = 4;
   localparam logic [ADDR_W-1:0] OFS_CFG    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SLOT   = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_TOFF   = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_THOLD  = 8'h03;

   // ------------
   // field positions
   // ------------
   localparam int CTRL_PERMIT   = 0;
   localparam int CMD_PANEL     = 0;
   localparam int CMD_SCADA_ALL = 1;
   localparam int CFG_COLL_INV  = 0;
   localparam int CFG_CLOSED    = 1;
   localparam int CFG_LATCH     = 2;
   localparam int CFG_CLR_LSB   = 8;
   localparam int CFG_SINV_LSB  = 16;

   // ------------
   // reset values
   // ------------
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
   localparam logic [T_W-1:0]    RST_T    = 16'h0000;

endpackage : bioc_pkg

// ===== bioc_binary_io.sv
// bioc_binary_io: debounced digital inputs, output relay logic with
// latching, retention and dwell, plus the fixed health contact and LED.
// assumes synchronous inputs and an external retained store for latches.
//
// The strobed register port and the placing of the registers were chosen for this implementation.

`timescale 1ns/1ns
`default_nettype none

module bioc_binary_io
   import bioc_pkg::*;
#(
   parameter int N_OUT    = 4,                   // relays, at most 8
   parameter int TICK_CYC = bioc_pkg::TICK_CYC   // clock cycles per tick
)(
   input  wire logic                       mclk_i,                      // clock
   input  wire logic                       reset_n_i,                   // reset
   input  wire logic [bioc_pkg::ADDR_W-1:0] addr_i,                     // reg addr
   input  wire logic [bioc_pkg::DATA_W-1:0] wr_data_i,                  // wr data
   input  wire logic                       wr_i,                        // wr strobe
   input  wire logic                       rd_i,                        // rd strobe
   output logic      [bioc_pkg::DATA_W-1:0] rd_data_o,                  // rd data
   input  wire logic [bioc_pkg::N_IN-1:0]  din_raw_i,                   // field in
   input  wire logic [bioc_pkg::N_EXT-1:0] ext_sig_i,                   // triggers
   input  wire logic                       panel_clear_i,               // C key
   input  wire logic                       all_outputs_clear_signal_i,  // clr all
   input  wire logic                       boot_done_i,                 // booted
   input  wire logic                       int_fault_i,                 // fault
   input  wire logic [N_OUT-1:0]           nv_latch_i,                  // retained
   output logic      [N_OUT-1:0]           relay_o,                     // coils
   output logic      [N_OUT-1:0]           nv_latch_o,                  // to store
   output logic                            health_contact_o,            // life
   output logic                            health_led_o                 // OK LED
);
   import bioc_pkg::*;

   localparam int TK_W = $clog2(TICK_CYC + 1);
   localparam int FL_W = $clog2(FLASH_TICKS + 1);
   localparam logic [TK_W-1:0] TICK_LAST = TK_W'(TICK_CYC - 1);
   localparam logic [FL_W-1:0] FLASH_LAST = FL_W'(FLASH_TICKS - 1);

   // ------------------------------------------------------------
   // tick divider and flash generator
   // ------------------------------------------------------------
   logic [TK_W-1:0] tick_cnt_r, tick_cnt_nxt;
   logic            tick_r, tick_nxt;
   logic [FL_W-1:0] fl_cnt_r, fl_cnt_nxt;
   logic            flash_r, flash_nxt;

   always_comb
   begin
      tick_nxt   = (tick_cnt_r == TICK_LAST);
      tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 1'b1;
      fl_cnt_nxt = fl_cnt_r;
      flash_nxt  = flash_r;
      if (tick_r)
      begin
         fl_cnt_nxt = (fl_cnt_r == FLASH_LAST) ? '0 : fl_cnt_r + 1'b1;
         if (fl_cnt_r == FLASH_LAST)
            flash_nxt = ~flash_r;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
         fl_cnt_r   <= '0;
         flash_r    <= 1'b0;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_nxt;
         tick_r     <= tick_nxt;
         fl_cnt_r   <= fl_cnt_nxt;
         flash_r    <= flash_nxt;
      end
   end

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
   logic [N_IN-1:0]   in_inv_r, in_inv_nxt;
   logic [T_W-1:0]    db_time_r [N_IN];
   logic [T_W-1:0]    db_time_nxt [N_IN];
   logic [DATA_W-1:0] cfg_r [N_OUT];
   logic [DATA_W-1:0] cfg_nxt [N_OUT];
   logic [DATA_W-1:0] slot_r [N_OUT];
   logic [DATA_W-1:0] slot_nxt [N_OUT];
   logic [T_W-1:0]    toff_r [N_OUT];
   logic [T_W-1:0]    toff_nxt [N_OUT];
   logic [T_W-1:0]    thold_r [N_OUT];
   logic [T_W-1:0]    thold_nxt [N_OUT];
   logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
   logic              cmd_wr;

   logic [N_IN-1:0]   din_cond;
   logic [N_OUT-1:0]  contact_st;
   logic [N_OUT-1:0]  latch_st;

   function automatic logic [ADDR_W-1:0] out_addr(input int j,
                                                   input logic [ADDR_W-1:0] o);
      out_addr = A_OUT_BASE + ADDR_W'(j * OUT_STRIDE) + o;
   endfunction : out_addr

   assign cmd_wr = wr_i && (addr_i == A_CMD);

   always_comb
   begin
      ctrl_nxt    = ctrl_r;
      in_inv_nxt  = in_inv_r;
      db_time_nxt = db_time_r;
      cfg_nxt     = cfg_r;
      slot_nxt    = slot_r;
      toff_nxt    = toff_r;
      thold_nxt   = thold_r;
      rd_data_nxt = '0;
      if (wr_i)
      begin
         if (addr_i == A_CTRL)
            ctrl_nxt = wr_data_i;
         if (addr_i == A_IN_INV)
            in_inv_nxt = wr_data_i[N_IN-1:0];
         for (int i = 0; i < N_IN; i++)
            if (addr_i == A_DB_BASE + ADDR_W'(i))
               db_time_nxt[i] = wr_data_i[T_W-1:0];
         for (int j = 0; j < N_OUT; j++)
         begin
            if (addr_i == out_addr(j, OFS_CFG))
               cfg_nxt[j] = wr_data_i;
            if (addr_i == out_addr(j, OFS_SLOT))
               slot_nxt[j] = wr_data_i;
            if (addr_i == out_addr(j, OFS_TOFF))
               toff_nxt[j] = wr_data_i[T_W-1:0];
            if (addr_i == out_addr(j, OFS_THOLD))
               thold_nxt[j] = wr_data_i[T_W-1:0];
         end
      end
      // read data live for exactly the cycle after the strobe
      if (rd_i)
      begin
         if (addr_i == A_CTRL)
            rd_data_nxt = ctrl_r;
         if (addr_i == A_IN_INV)
            rd_data_nxt = DATA_W'(in_inv_r);
         if (addr_i == A_DIN)
            rd_data_nxt = DATA_W'(din_cond);
         if (addr_i == A_OUT)
            rd_data_nxt = DATA_W'(contact_st);
         if (addr_i == A_LATCH)
            rd_data_nxt = DATA_W'(latch_st);
         if (addr_i == A_HEALTH)
            rd_data_nxt = DATA_W'({health_led_o, health_contact_o});
         for (int i = 0; i < N_IN; i++)
            if (addr_i == A_DB_BASE + ADDR_W'(i))
               rd_data_nxt = DATA_W'(db_time_r[i]);
         for (int j = 0; j < N_OUT; j++)
         begin
            if (addr_i == out_addr(j, OFS_CFG))
               rd_data_nxt = cfg_r[j];
            if (addr_i == out_addr(j, OFS_SLOT))
               rd_data_nxt = slot_r[j];
            if (addr_i == out_addr(j, OFS_TOFF))
               rd_data_nxt = DATA_W'(toff_r[j]);
            if (addr_i == out_addr(j, OFS_THOLD))
               rd_data_nxt = DATA_W'(thold_r[j]);
         end
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_r    <= RST_WORD;
         in_inv_r  <= '0;
         rd_data_r <= RST_WORD;
         for (int i = 0; i < N_IN; i++)
            db_time_r[i] <= RST_T;
         for (int j = 0; j < N_OUT; j++)
         begin
            cfg_r[j]   <= RST_WORD;
            slot_r[j]  <= RST_WORD;
            toff_r[j]  <= RST_T;
            thold_r[j] <= RST_T;
         end
      end
      else
      begin
         ctrl_r      <= ctrl_nxt;
         in_inv_r    <= in_inv_nxt;
         rd_data_r   <= rd_data_nxt;
         db_time_r   <= db_time_nxt;
         cfg_r       <= cfg_nxt;
         slot_r      <= slot_nxt;
         toff_r      <= toff_nxt;
         thold_r     <= thold_nxt;
      end
   end

   assign rd_data_o = rd_data_r;

   // ------------------------------------------------------------
   // input debounce
   // ------------------------------------------------------------
   logic [N_IN-1:0] acc_r, acc_nxt;
   logic [N_IN-1:0] db_run_r, db_run_nxt;
   logic [T_W-1:0]  db_cnt_r [N_IN];
   logic [T_W-1:0]  db_cnt_nxt [N_IN];

   always_comb
   begin
      acc_nxt    = acc_r;
      db_run_nxt = db_run_r;
      db_cnt_nxt = db_cnt_r;
      for (int i = 0; i < N_IN; i++)
      begin
         if (!db_run_r[i])
         begin
            if (din_raw_i[i] != acc_r[i])
            begin
               acc_nxt[i]    = din_raw_i[i];
               db_run_nxt[i] = 1'b1;
               db_cnt_nxt[i] = '0;
            end
         end
         else if (db_cnt_r[i] >= db_time_r[i])
            db_run_nxt[i] = 1'b0;
         else if (tick_r)
            db_cnt_nxt[i] = db_cnt_r[i] + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         acc_r    <= '0;
         db_run_r <= '0;
         for (int i = 0; i < N_IN; i++)
            db_cnt_r[i] <= RST_T;
      end
      else
      begin
         acc_r    <= acc_nxt;
         db_run_r <= db_run_nxt;
         db_cnt_r <= db_cnt_nxt;
      end
   end

   assign din_cond = acc_r ^ in_inv_r;

   // ------------------------------------------------------------
   // common clear requests and restore flag
   // ------------------------------------------------------------
   logic [N_SRC-1:0] src_vec;
   logic             panel_clr;
   logic             global_clr;
   logic             restore_r;

   assign src_vec   = {ext_sig_i, din_cond, 1'b0};
   assign panel_clr = panel_clear_i || (cmd_wr && wr_data_i[CMD_PANEL]);
   assign global_clr = ctrl_r[CTRL_PERMIT] &&
                       (all_outputs_clear_signal_i ||
                        (cmd_wr && wr_data_i[CMD_SCADA_ALL]));

   // latches come back from the retained store one cycle after release
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         restore_r <= 1'b1;
      else
         restore_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // output relay channels
   // ------------------------------------------------------------
   for (genvar j = 0; j < N_OUT; j++)
   begin : g_out
      logic [N_SLOT-1:0] slot_sig;
      logic [N_SLOT-1:0] slot_used;
      logic              trig_or;
      logic              comb_st;
      logic              own_clr;
      logic              clr_req;
      logic              ack_ok;
      logic              demand;
      logic [SRC_W-1:0]  clr_src;
      logic              latch_r, latch_nxt;
      logic              st_r, st_nxt;
      logic              coil_r, coil_nxt;
      logic [T_W-1:0]    off_cnt_r, off_cnt_nxt;
      logic [T_W-1:0]    hold_cnt_r, hold_cnt_nxt;

      always_comb
      begin
         for (int k = 0; k < N_SLOT; k++)
         begin
            slot_used[k] = (slot_r[j][k*SRC_W +: SRC_W] != '0);
            slot_sig[k]  = slot_used[k] &&
                           (src_vec[slot_r[j][k*SRC_W +: SRC_W]] ^
                            cfg_r[j][CFG_SINV_LSB + k]);
         end
      end

      assign trig_or = |slot_sig;
      assign comb_st = (|slot_used) &&
                       (trig_or ^ cfg_r[j][CFG_COLL_INV]);
      assign clr_src = cfg_r[j][CFG_CLR_LSB +: SRC_W];
      assign own_clr = cfg_r[j][CFG_LATCH] && (clr_src != '0) &&
                       src_vec[clr_src];
      assign clr_req = panel_clr || own_clr || global_clr ||
                       !cfg_r[j][CFG_LATCH] || !(|slot_used);
      // clear only once the setting state is gone and retention ran out
      assign ack_ok  = !comb_st && (off_cnt_r >= toff_r[j]);

      always_comb
      begin
         latch_nxt   = latch_r;
         off_cnt_nxt = off_cnt_r;
         if (comb_st)
            off_cnt_nxt = '0;
         else if (tick_r && (off_cnt_r < toff_r[j]))
            off_cnt_nxt = off_cnt_r + 1'b1;
         if (restore_r)
            latch_nxt = nv_latch_i[j];
         else if (cfg_r[j][CFG_LATCH] && comb_st)
            latch_nxt = 1'b1;
         else if (clr_req && ack_ok)
            latch_nxt = 1'b0;
      end

      // set beats clear: a set state in the clear cycle keeps the latch
      assign demand = cfg_r[j][CFG_LATCH] ? (latch_r || comb_st)
                                          : comb_st;

      always_comb
      begin
         st_nxt       = st_r;
         hold_cnt_nxt = hold_cnt_r;
         if ((demand != st_r) && (hold_cnt_r >= thold_r[j]))
         begin
            st_nxt       = demand;
            hold_cnt_nxt = '0;
         end
         else if (tick_r && (hold_cnt_r < thold_r[j]))
            hold_cnt_nxt = hold_cnt_r + 1'b1;
         coil_nxt = st_nxt ^ cfg_r[j][CFG_CLOSED];
      end

      always_ff @(posedge mclk_i or negedge reset_n_i)
      begin
         if (!reset_n_i)
         begin
            latch_r    <= 1'b0;
            st_r       <= 1'b0;
            coil_r     <= 1'b0;
            off_cnt_r  <= RST_T;
            hold_cnt_r <= RST_T;
         end
         else
         begin
            latch_r    <= latch_nxt;
            st_r       <= st_nxt;
            coil_r     <= coil_nxt;
            off_cnt_r  <= off_cnt_nxt;
            hold_cnt_r <= hold_cnt_nxt;
         end
      end

      assign relay_o[j]    = coil_r;
      assign nv_latch_o[j] = latch_r;
      assign contact_st[j] = st_r;
      assign latch_st[j]   = latch_r;
   end

   // ------------------------------------------------------------
   // health contact and LED
   // ------------------------------------------------------------
   logic contact_r, contact_nxt;
   logic led_r, led_nxt;

   always_comb
   begin
      contact_nxt = boot_done_i && !int_fault_i;
      led_nxt     = boot_done_i ? 1'b1 : flash_r;
   end

   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         contact_r <= 1'b0;
         led_r     <= 1'b0;
      end
      else
      begin
         contact_r <= contact_nxt;
         led_r     <= led_nxt;
      end
   end

   assign health_contact_o = contact_r;
   assign health_led_o     = led_r;

endmodule : bioc_binary_io

`default_nettype wire

// ===== bioc_binary_io_props.sv
// bioc_binary_io_props: port checks of the binary I/O block.
// assumes a bind to bioc_binary_io, one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
module bioc_props
   import bioc_pkg::*;
#(
   parameter int N_OUT    = 4,  // relays
   parameter int TICK_CYC = 10  // cycles a tick
)(
   input wire logic                        mclk_i,           // clk
   input wire logic                        reset_n_i,        // rst
   input wire logic                        rd_i,             // rd
   input wire logic [bioc_pkg::DATA_W-1:0] rd_data_o,        // data
   input wire logic                        boot_done_i,      // boot
   input wire logic                        int_fault_i,      // fault
   input wire logic [N_OUT-1:0]            nv_latch_i,       // store
   input wire logic [N_OUT-1:0]            nv_latch_o,       // latch
   input wire logic [N_OUT-1:0]            relay_o,          // coils
   input wire logic                        health_contact_o, // life
   input wire logic                        health_led_o      // led
);
   // ------------
   // led flash watch
   // ------------
   // slack of a few cycles for the tick prescaler phase
   localparam int FLASH_MAX = FLASH_TICKS * TICK_CYC + 4;
   logic [31:0] fl_cnt_r;
   logic        led_r;
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         fl_cnt_r <= '0;
         led_r    <= 1'b0;
      end
      else
      begin
         led_r    <= health_led_o;
         fl_cnt_r <= (boot_done_i || led_r != health_led_o) ? '0
                                                             : fl_cnt_r + 1;
      end
   end
   // ------------
   // assertions
   // ------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   a_rd_idle_zero: assert property
      (!$past(rd_i) |-> rd_data_o == '0) else $error("read data not idle");
   a_reset_outs_quiet: assert property
      (!$past(reset_n_i) |-> relay_o == '0 && !health_contact_o)
      else $error("outputs active at release");
   a_boot_contact_off: assert property
      (!boot_done_i |=> !health_contact_o) else $error("contact in boot");
   a_fault_contact_off: assert property
      (int_fault_i |=> !health_contact_o) else $error("contact on fault");
   a_good_contact_on: assert property
      ((boot_done_i && !int_fault_i) [*2] |=> health_contact_o)
      else $error("contact not picked up");
   a_booted_led_on: assert property
      (boot_done_i [*2] |=> health_led_o) else $error("led not steady");
   a_led_flash_rate: assert property
      (!boot_done_i |-> fl_cnt_r <= FLASH_MAX) else $error("led not flashing");
   a_restore_latch: assert property
      (!$past(reset_n_i) |=> nv_latch_o == $past(nv_latch_i))
      else $error("latch not restored");
endmodule : bioc_props
bind bioc_binary_io bioc_props #(.N_OUT(N_OUT), .TICK_CYC(TICK_CYC))
   u_props (.*);
`default_nettype wire

// ===== bioc_field.sv
// bioc_field: field side model, bouncing contacts and latch store.
// assumes level changes no closer than the bounce span.
`timescale 1ns/1ns
`default_nettype none
module bioc_field
   import bioc_pkg::*;
#(
   parameter int N_OUT = 4  // relays
)(
   input  wire logic                      mclk_i,    // clk
   input  wire logic                      reset_n_i, // device rst
   input  wire logic [bioc_pkg::N_IN-1:0] level_i,   // wanted level
   input  wire logic [N_OUT-1:0]          store_d_i, // latch state
   output var  logic [bioc_pkg::N_IN-1:0] din_o,     // to inputs
   output var  logic [N_OUT-1:0]          store_q_o  // restored
);
   logic [N_IN-1:0] lvl_r = '0;
   logic [N_IN-1:0] chg_r = '0;
   logic [2:0]      bnc_r = '0;
   logic            run_r = 1'b0;
   initial din_o = '0;
   initial store_q_o = '0;
   // changed bits chatter back to the old level a few times
   always @(posedge mclk_i)
   begin
      if (level_i != lvl_r)
      begin
         lvl_r <= level_i;
         chg_r <= level_i ^ lvl_r;
         bnc_r <= 3'h5;
         din_o <= level_i;
      end
      else
      begin
         din_o <= (bnc_r != 3'h0 && bnc_r[0]) ? lvl_r ^ chg_r : lvl_r;
         if (bnc_r != 3'h0)
            bnc_r <= bnc_r - 3'h1;
      end
      // frozen in reset and one cycle after, while latches reload
      run_r <= reset_n_i;
      if (reset_n_i && run_r)
         store_q_o <= store_d_i;
   end
endmodule : bioc_field
`default_nettype wire

// ===== binary_io_conditioning_test.sv
// binary_io_conditioning_test: self-checking bench of the I/O block.
// assumes bioc_field beside the block, bioc_props bound into it.
`timescale 1ns/1ns
`default_nettype none
module binary_io_conditioning_test;
   import bioc_pkg::*;
   logic        mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0]  addr = 8'h00, lvl = 8'h00, din;
   logic [31:0] wdata = 32'h0, rdata;
   logic [6:0]  ext = 7'h00;
   logic        pclr = 1'b0, aclr = 1'b0, boot = 1'b0, fault = 1'b0;
   logic [3:0]  nvi, nvo, relay;
   logic        hc, led;
   int          miscompares = 0, n_compared = 0;
   localparam logic [7:0] O0 = A_OUT_BASE;
   localparam logic [31:0] T_CFG [11] = '{32'h0, 32'h0, 32'h0,
      32'h0002_0000, 32'h0002_0000, 32'h007C_0000, 32'h1, 32'h1,
      32'h2, 32'h2, 32'h0};
   localparam logic [31:0] T_SLOT [11] = '{32'hA9, 32'hA9, 32'hA9,
      32'hA9, 32'hA9, 32'hA9, 32'hA9, 32'h0, 32'hA9, 32'hA9,
      32'h0F00_0000};
   localparam logic [6:0] T_EXT [11] = '{7'h0, 7'h1, 7'h2, 7'h0, 7'h2,
      7'h0, 7'h0, 7'h0, 7'h0, 7'h1, 7'h40};
   localparam logic [0:10] T_EXP = 11'h395;
   initial forever #50 mclk = ~mclk;
   bioc_binary_io #(.N_OUT(4), .TICK_CYC(10)) dut (.mclk_i(mclk),
      .reset_n_i(rst_n), .addr_i(addr), .wr_data_i(wdata), .wr_i(wr),
      .rd_i(rd), .rd_data_o(rdata), .din_raw_i(din), .ext_sig_i(ext),
      .panel_clear_i(pclr), .all_outputs_clear_signal_i(aclr),
      .boot_done_i(boot), .int_fault_i(fault), .nv_latch_i(nvi),
      .relay_o(relay), .nv_latch_o(nvo), .health_contact_o(hc),
      .health_led_o(led));
   bioc_field #(.N_OUT(4)) u_field (.mclk_i(mclk), .reset_n_i(rst_n),
      .level_i(lvl), .store_d_i(nvo), .din_o(din), .store_q_o(nvi));
   // ------------
   // shared tasks
   // ------------
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   task automatic chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1)
      begin
         miscompares++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask : chk
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wrr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(rdata === e, "read data");
   endtask : rdc
   task automatic rel(input logic e, input string msg);
      @(negedge mclk);
      chk(relay[0] === e, msg);
   endtask : rel
   // set the latch from ext0, then let the trigger drop
   task automatic arm(input logic [31:0] cfg);
      wrr(O0, cfg);
      wrr(O0 + 8'h01, 32'h9);
      ext <= 7'h01;
      cyc(3);
      ext <= 7'h00;
      cyc(3);
      rel(1'h1, "latch lost");
   endtask : arm
   task automatic ack(input logic all);
      @(posedge mclk);
      if (all) aclr <= 1'b1; else pclr <= 1'b1;
      @(posedge mclk);
      aclr <= 1'b0;
      pclr <= 1'b0;
      cyc(3);
   endtask : ack
   task automatic do_reset;
      @(posedge mclk);
      rst_n <= 1'b0;
      cyc(20);
      rst_n <= 1'b1;
      cyc(2);
   endtask : do_reset
   task final_report;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   // ------------
   // scenarios
   // ------------
   task automatic t_boot;
      logic hi, lo, cont;
      hi = 1'b0;
      lo = 1'b0;
      cont = 1'b0;
      repeat (6000)
      begin
         @(negedge mclk);
         hi = hi | (led === 1'b1);
         lo = lo | (led === 1'b0);
         cont = cont | (hc !== 1'b0);
      end
      chk(hi && lo, "led not flashing in boot");
      chk(!cont, "contact up in boot");
      boot <= 1'b1;
      cyc(4);
      chk(led === 1'b1 && hc === 1'b1, "health after boot");
      fault <= 1'b1;
      cyc(4);
      chk(hc === 1'b0, "contact on fault");
      fault <= 1'b0;
   endtask : t_boot
   task automatic t_regs;
      rdc(A_CTRL, 32'h0);
      rdc(A_LATCH, 32'h0);
      rdc(A_DB_BASE, 32'h0);
      rdc(O0, 32'h0);
      rdc(8'hFF, 32'h0);
      wrr(A_CTRL, 32'h1);
      rdc(A_CTRL, 32'h1);
      wrr(A_CTRL, 32'h0);
   endtask : t_regs
   task automatic t_debounce;
      wrr(A_DB_BASE, 32'h5);
      lvl <= 8'h01;
      cyc(4);
      rdc(A_DIN, 32'h1);
      lvl <= 8'h00;
      cyc(10);
      rdc(A_DIN, 32'h1);
      cyc(70);
      rdc(A_DIN, 32'h0);
      wrr(A_IN_INV, 32'h1);
      rdc(A_DIN, 32'h1);
      wrr(A_IN_INV, 32'h0);
   endtask : t_debounce
   task automatic t_logic;
      for (int i = 0; i < 11; i++)
      begin
         wrr(O0, T_CFG[i]);
         wrr(O0 + 8'h01, T_SLOT[i]);
         ext <= T_EXT[i];
         cyc(3);
         rel(T_EXP[i], "combined state");
      end
      ext <= 7'h00;
   endtask : t_logic
   task automatic t_latch;
      wrr(O0 + 8'h02, 32'h3);
      arm(32'h4);
      chk(nvo[0] === 1'b1, "latch not stored");
      ack(1'b0);
      rel(1'h1, "ack inside retention");
      cyc(50);
      ack(1'b0);
      rel(1'h0, "panel clear");
      arm(32'h0000_0A04);
      cyc(50);
      ext <= 7'h03;
      cyc(3);
      ext <= 7'h02;
      cyc(3);
      rel(1'h1, "own clear too early");
      cyc(50);
      rel(1'h0, "own clear");
      ext <= 7'h00;
      arm(32'h4);
      cyc(50);
      wrr(O0, 32'h0);
      cyc(3);
      rel(1'h0, "unlatch clear");
      chk(nvo[0] === 1'b0, "latch kept");
      arm(32'h4);
      cyc(50);
      wrr(O0 + 8'h01, 32'h0);
      cyc(3);
      rel(1'h0, "unassigned clear");
      arm(32'h4);
      cyc(50);
      ack(1'b1);
      rel(1'h1, "global clear without permit");
      wrr(A_CTRL, 32'h1);
      ack(1'b1);
      rel(1'h0, "global clear");
      arm(32'h4);
      cyc(50);
      wrr(A_CMD, 32'h2);
      cyc(3);
      rel(1'h0, "scada clear");
      wrr(A_CTRL, 32'h0);
      arm(32'h4);
      do_reset();
      chk(nvi[0] === 1'b1, "store lost");
   endtask : t_latch
   task automatic t_dwell;
      wrr(O0 + 8'h03, 32'h5);
      wrr(O0, 32'h0);
      wrr(O0 + 8'h01, 32'h9);
      cyc(60);
      ext <= 7'h01;
      cyc(3);
      rel(1'h1, "pickup");
      ext <= 7'h00;
      cyc(20);
      rel(1'h1, "dwell too short");
      cyc(50);
      rel(1'h0, "release after dwell");
   endtask : t_dwell
   initial
   begin
      #5_000_000;
      miscompares++;
      final_report();
   end
   initial
   begin
      cyc(20);
      rst_n <= 1'b1;
      cyc(1);
      t_boot();
      t_regs();
      t_debounce();
      t_logic();
      t_latch();
      t_dwell();
      final_report();
   end
endmodule : binary_io_conditioning_test
`default_nettype wire
